// ==== hw/pcg_params.svh ====
// Overview of operation
// - a set gate bit 3 lets the watchdog be clocked and work, a clear bit stops its clock; no other gate bit, not even bit 6, opens a clock.
// - an access aimed at a unit whose clock is off returns a bus fault, not a completion.
// - after reset every gate bit except read-only bit 6 is zero, so all gated units start without a clock.
// - bit 3 of the run and sleep gate registers is a read/write watchdog gate, reset 0.
// - the run gate register sits at offset 0x100 and rules the clocks while running.
// - the sleep gate register sits at 0x110; the deep-sleep set comes from the I_DEEP_SLEEP_CLOCK_GATE_0 input.
// - the power state picks the gate set: run, sleep or deep sleep.
// - sleep and deep-sleep sets act only when automatic sleep gating is enabled.
// - bits 31:7, 5:4 and 2:0 are read-only zero and bit 6 reads one; software keeps them across read-modify-write.
// - the gate registers read 0x00000040 after reset, as the whole-word value is given.
// - the read-only presence register at 0x01C shows ports A and B as ones.
// - a port's presence bit uses the same index as in the second gate set.
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH

// ================================================================
// register map (byte offsets)
`define PCG_ADDR_W        12
`define PCG_OFS_PRESENCE  12'h01c
`define PCG_OFS_RUN0      12'h100
`define PCG_OFS_SLEEP0    12'h110

// ================================================================
// field layout and reset values
`define PCG_GATE_RESET    32'h00000040
`define PCG_GATE_WR_MASK  32'h00000008
`define PCG_GATE_RO_ONES  32'h00000040
`define PCG_WDT_BIT       3
`define PCG_PORT_A_BIT    0
`define PCG_PORT_B_BIT    1
`define PCG_ZERO_WORD     32'h00000000

`endif

// ==== hw/pcg_pkg.sv ====
`include "pcg_params.svh"

package pcg_pkg;

	// ================================================================
	// power states
	typedef enum logic [1:0] {
		PCG_PWR_RUN,
		PCG_PWR_SLEEP,
		PCG_PWR_DEEP
	} pcg_pwr_t;

	// ================================================================
	// register-side state of the top module
	typedef struct packed {
		logic [31:0] run_gate;
		logic [31:0] sleep_gate;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic [31:0] unit_fault;
	} pcg_regs_t;

	// state of the enable selector
	typedef struct packed {
		logic [31:0] clk_en;
	} pcg_sel_t;

endpackage

// ==== hw/pcg_sel_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface pcg_sel_if;
	import pcg_pkg::*;
	logic [31:0] run_gate;
	logic [31:0] sleep_gate;
	logic [31:0] deep_gate;
	logic [1:0]  power_state;
	logic        auto_gate;
	logic [31:0] clk_en;

	modport ctrl (
		output run_gate,
		output sleep_gate,
		output deep_gate,
		output power_state,
		output auto_gate,
		input  clk_en
	);
	modport sel (
		input  run_gate,
		input  sleep_gate,
		input  deep_gate,
		input  power_state,
		input  auto_gate,
		output clk_en
	);
endinterface

`default_nettype wire

// ==== hw/pcg_gate_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcg_params.svh"

module pcg_gate_sel
	import pcg_pkg::*;
#(
	parameter int NUM_BITS = 32
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	// gate sets in, enables out
	pcg_sel_if.sel    bus
);

	pcg_sel_t        st_r;
	pcg_sel_t        st_nxt;
	logic [31:0]     pick;
	pcg_pwr_t        pwr;

	assign pwr = pcg_pwr_t'(bus.power_state);

	// ================================================================
	// per-bit choice of gate set
	genvar g;
	generate
		for (g = 0; g < NUM_BITS; g++) begin : g_bit
			// one driver per bit; auto gating off leaves the run set in charge
			assign pick[g] = !bus.auto_gate ? bus.run_gate[g] :
				(pwr == PCG_PWR_SLEEP) ? bus.sleep_gate[g] :
				(pwr == PCG_PWR_DEEP)  ? bus.deep_gate[g]  :
				bus.run_gate[g];
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		// only writable positions may ever open a clock
		st_nxt.clk_en = pick & `PCG_GATE_WR_MASK;
	end

	// enable settles just after the rising edge, so it is stable for the
	// whole low phase that a latch-based gate cell samples
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r.clk_en <= `PCG_ZERO_WORD;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus.clk_en = st_r.clk_en;

endmodule

`default_nettype wire

// ==== hw/pcg_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcg_params.svh"

module pcg_top
	import pcg_pkg::*;
#(
	parameter bit PORT_A_PRESENT = 1'b1,
	parameter bit PORT_B_PRESENT = 1'b1
) (
	// clock and reset
	input  wire logic                   I_CLOCK,
	input  wire logic                   I_RESET_N,
	// apb slave
	input  wire logic                   I_PSEL,
	input  wire logic                   I_PENABLE,
	input  wire logic                   I_PWRITE,
	input  wire logic [`PCG_ADDR_W-1:0] I_PADDR,
	input  wire logic [31:0]            I_PWDATA,
	input  wire logic [3:0]             I_PSTRB,
	output logic                        O_PREADY,
	output logic [31:0]                 O_PRDATA,
	output logic                        O_PSLVERR,
	// power state and sleep gating
	input  wire logic [1:0]             I_POWER_STATE,
	input  wire logic                   I_AUTO_SLEEP_GATING_ENABLE,
	input  wire logic [31:0]            I_DEEP_SLEEP_CLOCK_GATE_0,
	// gated units
	input  wire logic [31:0]            I_UNIT_ACCESS,
	output logic [31:0]                 O_UNIT_CLK_EN,
	output logic [31:0]                 O_UNIT_FAULT
);

	pcg_regs_t   st_r;
	pcg_regs_t   st_nxt;
	pcg_sel_if   sel_bus ();

	logic        setup;
	logic        access;
	logic [31:0] strb_mask;
	logic [31:0] presence;
	logic        hit_run;
	logic        hit_sleep;
	logic        hit_pres;
	logic        aligned;

	// ================================================================
	// enable selection
	pcg_gate_sel #(
		.NUM_BITS (32)
	) u_sel (
		.i_clk     (I_CLOCK),
		.i_reset_n (I_RESET_N),
		.bus       (sel_bus.sel)
	);

	assign sel_bus.run_gate    = st_r.run_gate;
	assign sel_bus.sleep_gate  = st_r.sleep_gate;
	assign sel_bus.deep_gate   = I_DEEP_SLEEP_CLOCK_GATE_0;
	assign sel_bus.power_state = I_POWER_STATE;
	assign sel_bus.auto_gate   = I_AUTO_SLEEP_GATING_ENABLE;

	// ================================================================
	// decode
	assign setup     = I_PSEL && !I_PENABLE;
	assign access    = I_PSEL && I_PENABLE && st_r.pready;
	assign aligned   = (I_PADDR[1:0] == 2'h0);
	assign hit_pres  = aligned && (I_PADDR == `PCG_OFS_PRESENCE);
	assign hit_run   = aligned && (I_PADDR == `PCG_OFS_RUN0);
	assign hit_sleep = aligned && (I_PADDR == `PCG_OFS_SLEEP0);

	// same bit index as the second gate set
	always_comb begin
		presence = `PCG_ZERO_WORD;
		presence[`PCG_PORT_A_BIT] = PORT_A_PRESENT;
		presence[`PCG_PORT_B_BIT] = PORT_B_PRESENT;
	end

	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_lane
			assign strb_mask[8*b +: 8] = {8{I_PSTRB[b]}};
		end
	endgenerate

	// ================================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.pready = 1'b0;

		// zero-wait answer: ready is raised for the first access cycle
		if (setup) begin
			st_nxt.pready  = 1'b1;
			st_nxt.pslverr = !(hit_pres || hit_run || hit_sleep);
			st_nxt.prdata  = `PCG_ZERO_WORD;
			if (!I_PWRITE) begin
				if (hit_pres) begin
					st_nxt.prdata = presence;
				end else if (hit_run) begin
					st_nxt.prdata = st_r.run_gate;
				end else if (hit_sleep) begin
					st_nxt.prdata = st_r.sleep_gate;
				end
			end
		end

		// write lands only at the completing edge
		if (access && I_PWRITE && !st_r.pslverr) begin
			if (hit_run) begin
				st_nxt.run_gate = (st_r.run_gate & ~(`PCG_GATE_WR_MASK & strb_mask))
					| (I_PWDATA & `PCG_GATE_WR_MASK & strb_mask)
					| `PCG_GATE_RO_ONES;
			end
			if (hit_sleep) begin
				st_nxt.sleep_gate = (st_r.sleep_gate & ~(`PCG_GATE_WR_MASK & strb_mask))
					| (I_PWDATA & `PCG_GATE_WR_MASK & strb_mask)
					| `PCG_GATE_RO_ONES;
			end
		end
		if (access) begin
			st_nxt.prdata  = `PCG_ZERO_WORD;
			st_nxt.pslverr = 1'b0;
		end

		// unit access while its clock is stopped faults one cycle later, for as many cycles as the access lasts
		st_nxt.unit_fault = I_UNIT_ACCESS & ~sel_bus.clk_en;
	end

	// ================================================================
	// state register
	always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			st_r.run_gate   <= `PCG_GATE_RESET;
			st_r.sleep_gate <= `PCG_GATE_RESET;
			st_r.pready     <= 1'b0;
			st_r.prdata     <= `PCG_ZERO_WORD;
			st_r.pslverr    <= 1'b0;
			st_r.unit_fault <= `PCG_ZERO_WORD;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ================================================================
	// outputs
	assign O_PREADY      = st_r.pready;
	assign O_PRDATA      = st_r.prdata;
	assign O_PSLVERR     = st_r.pslverr;
	assign O_UNIT_FAULT  = st_r.unit_fault;
	assign O_UNIT_CLK_EN = sel_bus.clk_en;

endmodule

`default_nettype wire

// ==== test/pcg_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcg_top_chk (
	input wire logic        I_CLOCK,
	input wire logic        I_RESET_N,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_UNIT_ACCESS,
	input wire logic        O_PREADY,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_PSLVERR,
	input wire logic [31:0] O_UNIT_CLK_EN,
	input wire logic [31:0] O_UNIT_FAULT
);
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESET_N);
	// ================================================================
	// bus phases
	sequence setup_s; I_PSEL && !I_PENABLE; endsequence
	sequence rd_s(a); O_PREADY && !I_PWRITE && I_PADDR == a; endsequence
	chk_ready_next: assert property (setup_s |=> O_PREADY)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	chk_idle_data: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
		else $error("read data outside access");
	chk_gate_word: assert property ((rd_s(12'h100) or rd_s(12'h110))
		|-> (O_PRDATA & 32'hfffffff7) == 32'h40 && !O_PSLVERR)
		else $error("gate word fixed bits wrong");
	chk_presence_word: assert property (rd_s(12'h01c)
		|-> O_PRDATA == 32'h3 && !O_PSLVERR) else $error("presence wrong");
	chk_bad_addr: assert property (O_PREADY && I_PADDR == 12'h004 |-> O_PSLVERR)
		else $error("unmapped address accepted");
	chk_fault_off: assert property (I_UNIT_ACCESS[3] && !O_UNIT_CLK_EN[3]
		|=> O_UNIT_FAULT[3]) else $error("missing fault");
	chk_fault_cause: assert property (O_UNIT_FAULT[3]
		|-> $past(I_UNIT_ACCESS[3]) && !$past(O_UNIT_CLK_EN[3]))
		else $error("fault without cause");
	chk_en_mask: assert property ((O_UNIT_CLK_EN & 32'hfffffff7) == 0)
		else $error("enable on unused unit");
endmodule

bind pcg_top pcg_top_chk u_chk (.I_CLOCK, .I_RESET_N, .I_PSEL, .I_PENABLE,
	.I_PWRITE, .I_PADDR, .I_UNIT_ACCESS, .O_PREADY, .O_PRDATA, .O_PSLVERR,
	.O_UNIT_CLK_EN, .O_UNIT_FAULT);

`default_nettype wire

// ==== test/peripheral_clock_gating_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module peripheral_clock_gating_tb;
	import pcg_pkg::*;
	logic        clk, rst_n, psel, penable, pwrite, ready, err, auto_sleep_gating_enable, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, rdata, deep, acc, en, flt, rd, v, g;
	logic [31:0] run_m, slp_m;
	logic [1:0]  pst;
	logic [3:0]  strb;
	int          fails, num_checks, seed, x;

	pcg_top uut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .I_PSTRB(strb), .O_PREADY(ready),
		.O_PRDATA(rdata), .O_PSLVERR(err), .I_POWER_STATE(pst),
		.I_AUTO_SLEEP_GATING_ENABLE(auto_sleep_gating_enable), .I_DEEP_SLEEP_CLOCK_GATE_0(deep),
		.I_UNIT_ACCESS(acc), .O_UNIT_CLK_EN(en), .O_UNIT_FAULT(flt));

	// ================================================================
	// helpers
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// master holds everything until ready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees ready
		do begin
			@(posedge clk);
		end while (ready !== 1'b1);
		rd = rdata;
		e = err;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task rchk(input logic [11:0] a, input logic [31:0] exp, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, e}, {31'h0, ee});
	endtask

	task give_verdict;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ================================================================
	// clock, watchdog, sequence
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#400000;
		fails++;
		give_verdict;
	end

	initial begin
		seed = 32'h3a6ba0d0;
		{rst_n, psel, penable, pwrite, auto_sleep_gating_enable, pst} = '0;
		{paddr, pwdata, deep, acc, run_m, slp_m} = '0;
		strb = 4'hf;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(12'h100, 32'h40, 1'b0);
		rchk(12'h110, 32'h40, 1'b0);
		apb(1'b1, 12'h01c, 32'hffffffff);
		rchk(12'h01c, 32'h3, 1'b0);
		rchk(12'h004, 32'h0, 1'b1);
		rchk(12'h101, 32'h0, 1'b1);
		for (x = 0; x < 24; x++) begin
			v = $random(seed);
			// lane 0 strobe decides whether the watchdog bit is written
			strb <= v[7:4];
			apb(1'b1, x[0] ? 12'h110 : 12'h100, v);
			if (v[4] && x[0]) slp_m = v & 32'h8;
			if (v[4] && !x[0]) run_m = v & 32'h8;
			rchk(12'h100, run_m | 32'h40, 1'b0);
			rchk(12'h110, slp_m | 32'h40, 1'b0);
			v = $random(seed);
			pst <= v[1:0];
			auto_sleep_gating_enable <= v[2];
			deep <= $random(seed);
			repeat (2) @(posedge clk);
			g = (!auto_sleep_gating_enable || pst == 2'd0 || pst == 2'd3) ? run_m :
				(pst == 2'd1 ? slp_m : deep & 32'h8);
			chk(en, g);
			v = $random(seed);
			acc <= v;
			@(posedge clk);
			acc <= 32'h0;
			@(posedge clk);
			chk(flt, v & ~g);
		end
		// second reset in mid-run clears the gates again
		rst_n <= 1'b0;
		@(posedge clk);
		chk(en, 32'h0);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(12'h100, 32'h40, 1'b0);
		give_verdict;
	end
endmodule

`default_nettype wire
